// ---- dv/decoder_model.sv ----
// Behavioural picture decoder that answers the dispatcher's still requests
module decoder_model
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       flush_i,
    input  wire logic       decode_run_i,
    input  wire logic       hires_i,
    input  wire logic       stop_i,
    input  wire logic [3:0] delay_i,
    output logic            pic_done_o,
    output logic            pic_hires_o,
    output logic            audio_unit_o,
    output logic            stop_reached_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       armed;
    logic [3:0] count;
    // Resolution line follows hires_i while armed and through the done pulse, and reads low once stop_i has disarmed the model
    assign pic_hires_o    = (armed | pic_done_o) & hires_i;
    assign stop_reached_o = stop_i;
    // A flush while decoding is a plain buffer discard and starts no picture
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            armed        <= 1'b0;
            count        <= 4'h0;
            pic_done_o   <= 1'b0;
            audio_unit_o <= 1'b0;
        end
        else
        begin
            pic_done_o   <= 1'b0;
            audio_unit_o <= 1'b0;
            if (flush_i && !decode_run_i)
            begin
                armed <= 1'b1;
                count <= delay_i;
            end
            else if (armed && decode_run_i && count != 4'h0)
                count <= count - 4'h1;
            else if (armed && decode_run_i)
            begin
                pic_done_o   <= 1'b1;
                audio_unit_o <= 1'b1;
                armed        <= !stop_i;
                count        <= delay_i;
            end
        end
    end
endmodule : decoder_model

// ---- dv/testbench.sv ----
// Self-checking bench for the macro command dispatcher
`include "macro_cmd_cfg.svh"
`define CHECK(what, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
        end \
    end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic                   ref_clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   cmd_valid = 1'b0;
    macro_cmd_pkg::cmd_type cmd = '0;
    logic                   hires_cfg = 1'b0;
    logic                   hires = 1'b0;
    logic                   stop = 1'b1;
    logic                   pic_done, pic_hires, audio_unit, stop_reached;
    logic                   cmd_ready, cmd_error, set_strobe, transcode, ctrl_strobe;
    logic                   reinit, accept_bs, flush, decode_run, audio_run;
    logic [2:0]             cmd_state;
    logic [1:0]             group, display;
    logic [15:0]            set_code, ctrl_code;
    logic [63:0]            position;
    int                     errors = 0;
    int                     checks_done = 0;
    logic [15:0] set_codes [7] = '{`FC_BORDER_COLOR, `FC_ERROR_THRESHOLD, `FC_IRQ_ENABLE,
        `FC_STREAM_SELECT, `FC_VIDEO_STANDARD, `FC_WINDOW_GEOMETRY, `FC_AUDIO_SILENCE};
    logic [15:0] play_codes [11] = '{`FC_STILL_SINGLE, `FC_STILL_START, `FC_STILL_MULTI,
        `FC_SECTOR_DUMP, `FC_FREEZE, `FC_PAUSE, `FC_PLAY, `FC_PLAY_RANGE, `FC_SCAN,
        `FC_ONE_PICTURE, `FC_REDUCED_RATE};
    logic [63:0] pos_a = {16'h0130, 8'h15, `POS_MODE_BYTE, 32'h0};
    logic [63:0] pos_b = {16'h0130, 8'h15, `POS_MODE_BYTE, 16'h0145, 8'h00, `POS_MODE_BYTE};

    always #5 ref_clk = ~ref_clk;

    macro_cmd_dispatch u_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .cmd_valid_i(cmd_valid),
        .cmd_i(cmd), .hires_mode_cfg_i(hires_cfg), .pic_done_i(pic_done),
        .pic_hires_i(pic_hires), .audio_unit_i(audio_unit), .stop_reached_i(stop_reached),
        .cmd_ready_o(cmd_ready), .cmd_error_o(cmd_error), .cmd_state_o(cmd_state),
        .group_o(group), .set_code_o(set_code), .set_strobe_o(set_strobe),
        .transcode_check_o(transcode), .ctrl_code_o(ctrl_code), .ctrl_strobe_o(ctrl_strobe),
        .reinit_o(reinit), .accept_bitstream_o(accept_bs), .flush_o(flush),
        .decode_run_o(decode_run), .audio_run_o(audio_run), .display_o(display),
        .position_o(position));

    decoder_model u_decoder (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .flush_i(flush),
        .decode_run_i(decode_run), .hires_i(hires), .stop_i(stop), .delay_i(4'h4),
        .pic_done_o(pic_done), .pic_hires_o(pic_hires), .audio_unit_o(audio_unit),
        .stop_reached_o(stop_reached));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // Held for one taking edge; returns where the answer is settled
    task automatic issue(input logic [15:0] code, input logic [63:0] pos);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd = {code, pos};
        @(negedge ref_clk);
        cmd_valid = 1'b0;
    endtask : issue

    // Kind 0 waits for a state, 1 for ready, 2 for a finished picture
    task automatic wait_for(input int kind, input logic [2:0] target);
        int n;
        n = 0;
        while (!((kind == 0 && cmd_state === target) || (kind == 1 && cmd_ready === 1'b1)
                || (kind == 2 && pic_done === 1'b1)) && n < 40)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 40)
        begin
            errors++;
            $display("wrong value wait %0d expected reached seen timeout", kind);
            report_and_stop();
        end
    endtask : wait_for

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_settings(input logic [2:0] st);
        foreach (set_codes[i])
        begin
            issue(set_codes[i], '0);
            `CHECK("set_strobe", 1'b1, set_strobe)
            `CHECK("set_code", set_codes[i], set_code)
            `CHECK("group", 2'h0, group)
            `CHECK("state", st, cmd_state)
            `CHECK("transcode", set_codes[i] == `FC_VIDEO_STANDARD, transcode)
            `CHECK("ctrl_strobe", set_codes[i] == `FC_AUDIO_SILENCE, ctrl_strobe)
            `CHECK("error", 1'b0, cmd_error)
        end
        $display("test settings done");
    endtask : t_settings

    task automatic t_playback;
        foreach (play_codes[i])
        begin
            issue(play_codes[i], pos_b);
            `CHECK("group", 2'h1, group)
            `CHECK("state", 3'h1, cmd_state)
            `CHECK("ready", 1'b0, cmd_ready)
            `CHECK("accept", 1'b1, accept_bs)
            `CHECK("flush", i < 3, flush)
            issue(`FC_REINIT, '0);
            wait_for(1, 3'h0);
        end
        $display("test playback done");
    endtask : t_playback

    task automatic t_still(input logic cfg, input logic hr, input logic [1:0] disp);
        hires_cfg = cfg;
        hires = hr;
        issue(`FC_STREAM_SELECT, {8'h00, hr ? `STREAM_HIGH_RES : `STREAM_NORMAL_RES, 48'h0});
        repeat (3) @(negedge ref_clk);
        wait_for(1, 3'h0);
        issue(`FC_STILL_SINGLE, '0);
        `CHECK("flush", 1'b1, flush)
        `CHECK("display", 2'h1, display)
        repeat (2) @(negedge ref_clk);
        `CHECK("display", disp, display)
        wait_for(0, 3'h3);
        `CHECK("display", 2'h0, display)
        `CHECK("audio", 1'b1, audio_run)
        `CHECK("decode", 1'b1, decode_run)
        $display("test still done");
    endtask : t_still

    task automatic t_range;
        hires = 1'b0;
        issue(`FC_STILL_START, pos_a);
        wait_for(0, 3'h3);
        `CHECK("position", pos_a, position)
        `CHECK("state", 3'h3, cmd_state)
        stop = 1'b0;
        wait_for(1, 3'h0);
        issue(`FC_STILL_MULTI, pos_b);
        wait_for(2, 3'h0);
        @(negedge ref_clk);
        `CHECK("state", 3'h2, cmd_state)
        `CHECK("position", pos_b, position)
        stop = 1'b1;
        wait_for(0, 3'h3);
        `CHECK("audio", 1'b1, audio_run)
        $display("test range done");
    endtask : t_range

    task automatic t_control;
        issue(`FC_FILL_LEVEL_QUERY, '0);
        `CHECK("ctrl_strobe", 1'b1, ctrl_strobe)
        `CHECK("group", 2'h2, group)
        `CHECK("state", 3'h3, cmd_state)
        issue(`FC_BUFFER_DISCARD, '0);
        `CHECK("ctrl_code", `FC_BUFFER_DISCARD, ctrl_code)
        `CHECK("flush", 1'b1, flush)
        `CHECK("state", 3'h3, cmd_state)
        issue(`FC_REINIT, '0);
        `CHECK("reinit", 1'b1, reinit)
        `CHECK("state", 3'h0, cmd_state)
        issue(16'h1234, '0);
        `CHECK("error", 1'b1, cmd_error)
        $display("test control done");
    endtask : t_control

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (5) @(negedge ref_clk);
        `CHECK("group", 2'h3, group)
        `CHECK("state", 3'h0, cmd_state)
        rst_n = 1'b1;
        @(negedge ref_clk);
        `CHECK("ready", 1'b1, cmd_ready)
        t_settings(3'h0);
        t_playback();
        t_still(1'b0, 1'b0, 2'h1);
        t_still(1'b1, 1'b1, 2'h2);
        t_still(1'b1, 1'b1, 2'h3);
        t_still(1'b0, 1'b1, 2'h2);
        t_range();
        t_settings(3'h3);
        t_control();
        report_and_stop();
    end
endmodule : testbench

// ---- rtl/macro_cmd_cfg.svh ----
// Function codes, position mode, stream and high resolution mode values of the macro command dispatcher
`ifndef MACRO_CMD_CFG_SVH
`define MACRO_CMD_CFG_SVH
`define FC_BORDER_COLOR      16'h0207
`define FC_ERROR_THRESHOLD   16'h0119
`define FC_IRQ_ENABLE        16'h0104
`define FC_STREAM_SELECT     16'h0213
`define FC_VIDEO_STANDARD    16'h0305
`define FC_WINDOW_GEOMETRY   16'h0606
`define FC_STILL_SINGLE      16'h000C
`define FC_STILL_START       16'h020C
`define FC_STILL_MULTI       16'h040C
`define FC_SECTOR_DUMP       16'h0314
`define FC_FREEZE            16'h0010
`define FC_PAUSE             16'h000E
`define FC_PLAY              16'h000D
`define FC_PLAY_RANGE        16'h040D
`define FC_SCAN              16'h000A
`define FC_ONE_PICTURE       16'h000B
`define FC_REDUCED_RATE      16'h0109
`define FC_AUDIO_SILENCE     16'h8118
`define FC_BUFFER_DISCARD    16'h8002
`define FC_FILL_LEVEL_QUERY  16'h8001
`define FC_REINIT            16'h8000
`define POS_MODE_BYTE        8'h02
`define STREAM_NORMAL_RES    8'hE1
`define STREAM_HIGH_RES      8'hE2
`define HIRES_MODE_BLANK     1'b0
`define HIRES_MODE_OVERWRITE 1'b1
`endif

// ---- rtl/macro_cmd_dispatch.sv ----
// Macro command sorter and still-picture sequencer
`include "macro_cmd_cfg.svh"

// What this block does
// - Settings commands are accepted in any state and never change the state
// - Settings leave decoding alone; only video standard flags transcoding
// - Playback commands change state, suspend further playback commands, enter playback setup
// - Control commands are accepted in any state at high priority
// - Decode border colour 0207, error threshold 0119, irq enable 0104
// - Decode stream select 0213, video standard 0305, window 0606
// - Decode still codes 000C single, 020C from start, 040C slide show
// - Decode sector dump 0314, freeze 0010, pause 000E
// - Decode play 000D, play range 040D, intra scan 000A
// - Decode one picture 000B and reduced rate 0109
// - 8118, 8002, 8001 are high priority and keep the state
// - 8000 reinitialises the device and changes the state
// - Single still flushes, decodes next intra picture, shows it, then freezes
// - Normal resolution keeps display frozen until decoding completes
// - High resolution overwrite shows picture top to bottom while decoding
// - High resolution blanking blanks display as decoding starts
// - High resolution after normal resolution video blanks at once
// - Still from start decodes from the position, ends after first still
// - Slide show decodes stills until stop; audio starts at first unit
// - Default high resolution transition comes from a configuration bit
module macro_cmd_dispatch
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  cmd_valid_i,
    input  wire macro_cmd_pkg::cmd_type cmd_i,
    input  wire logic                  hires_mode_cfg_i,
    input  wire logic                  pic_done_i,
    input  wire logic                  pic_hires_i,
    input  wire logic                  audio_unit_i,
    input  wire logic                  stop_reached_i,
    output logic                       cmd_ready_o,
    output logic                       cmd_error_o,
    output logic [2:0]                 cmd_state_o,
    output logic [1:0]                 group_o,
    output logic [15:0]                set_code_o,
    output logic                       set_strobe_o,
    output logic                       transcode_check_o,
    output logic [15:0]                ctrl_code_o,
    output logic                       ctrl_strobe_o,
    output logic                       reinit_o,
    output logic                       accept_bitstream_o,
    output logic                       flush_o,
    output logic                       decode_run_o,
    output logic                       audio_run_o,
    output logic [1:0]                 display_o,
    output logic [63:0]                position_o
);

    // ****************************************
    // Decoding
    // ****************************************
    function automatic macro_cmd_pkg::group_type classify(input logic [15:0] c);
        case (c)
            `FC_BORDER_COLOR, `FC_ERROR_THRESHOLD, `FC_IRQ_ENABLE,
            `FC_STREAM_SELECT, `FC_VIDEO_STANDARD, `FC_WINDOW_GEOMETRY,
            `FC_AUDIO_SILENCE:
                classify = macro_cmd_pkg::GRP_SET;
            `FC_STILL_SINGLE, `FC_STILL_START, `FC_STILL_MULTI, `FC_SECTOR_DUMP,
            `FC_FREEZE, `FC_PAUSE, `FC_PLAY, `FC_PLAY_RANGE, `FC_SCAN,
            `FC_ONE_PICTURE, `FC_REDUCED_RATE:
                classify = macro_cmd_pkg::GRP_PLAY;
            `FC_BUFFER_DISCARD, `FC_FILL_LEVEL_QUERY, `FC_REINIT:
                classify = macro_cmd_pkg::GRP_CONTROL;
            default:
                classify = macro_cmd_pkg::GRP_NONE;
        endcase
    endfunction : classify

    macro_cmd_pkg::cmd_state_type state;
    macro_cmd_pkg::cmd_state_type next_state;
    logic        busy;
    logic [15:0] active_code;
    logic        last_hires;
    logic        hires_mode;
    logic        cfg_meta;
    logic        cfg_sync;

    wire macro_cmd_pkg::group_type grp = classify(cmd_i.code);
    wire take       = cmd_valid_i && (!busy || grp != macro_cmd_pkg::GRP_PLAY);
    // Control and the mute setting bypass a suspended command queue
    wire hi_prio    = cmd_i.code[15];
    wire is_set     = take && grp == macro_cmd_pkg::GRP_SET;
    wire is_play    = take && grp == macro_cmd_pkg::GRP_PLAY;
    wire is_ctrl    = take && grp == macro_cmd_pkg::GRP_CONTROL;
    wire is_reinit  = is_ctrl && cmd_i.code == `FC_REINIT;
    wire is_bad     = cmd_valid_i && grp == macro_cmd_pkg::GRP_NONE;
    wire is_still   = is_play && cmd_i.code[7:0] == 8'h0C;
    wire still_act  = state == macro_cmd_pkg::CS_STILL;
    wire multi      = active_code == `FC_STILL_MULTI;
    wire pos_ok     = cmd_i.start2[7:0] == `POS_MODE_BYTE;
    wire pic_end    = still_act && pic_done_i;
    wire still_fin  = pic_end && (!multi || stop_reached_i);

    // ****************************************
    // Command state
    // ****************************************
    always_comb
    begin
        next_state = state;
        case (state)
            macro_cmd_pkg::CS_PLAY_SETUP:
                next_state = (active_code[7:0] == 8'h0C) ? macro_cmd_pkg::CS_STILL
                           : (active_code == `FC_FREEZE)  ? macro_cmd_pkg::CS_FREEZE
                           : (active_code == `FC_PAUSE)   ? macro_cmd_pkg::CS_PAUSE
                           : macro_cmd_pkg::CS_PLAYING;
            macro_cmd_pkg::CS_STILL:
                if (still_fin)
                    next_state = macro_cmd_pkg::CS_FREEZE;
            default:
                next_state = state;
        endcase
        if (is_play)
            next_state = macro_cmd_pkg::CS_PLAY_SETUP;
        if (is_reinit)
            next_state = macro_cmd_pkg::CS_IDLE;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state       <= macro_cmd_pkg::CS_IDLE;
            active_code <= 16'h0000;
            busy        <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (is_play)
                active_code <= cmd_i.code;
            // Playback commands hold off further ones until setup finishes
            busy <= is_play ? 1'b1 : (is_reinit ? 1'b0 : (busy && state == next_state
                    && state == macro_cmd_pkg::CS_PLAY_SETUP));
        end
    end

    // Configuration strap is a pin: synchronise before use
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_meta <= 1'b0;
            cfg_sync <= 1'b0;
        end
        else
        begin
            cfg_meta <= hires_mode_cfg_i;
            cfg_sync <= cfg_meta;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic [1:0] next_display;
    always_comb
    begin
        next_display = display_o;
        if (is_still)
            next_display = macro_cmd_pkg::DISP_FROZEN;
        else if (still_act && pic_hires_i)
        begin
            if (!last_hires || hires_mode == `HIRES_MODE_BLANK)
                next_display = macro_cmd_pkg::DISP_BLANK;
            else
                next_display = macro_cmd_pkg::DISP_OVERWRITE;
        end
        if (pic_end)
            next_display = macro_cmd_pkg::DISP_LIVE;
        else if (is_play && !is_still)
            next_display = macro_cmd_pkg::DISP_LIVE;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cmd_ready_o        <= 1'b0;
            cmd_error_o        <= 1'b0;
            cmd_state_o        <= 3'h0;
            group_o            <= 2'h3;
            set_code_o         <= 16'h0000;
            set_strobe_o       <= 1'b0;
            transcode_check_o  <= 1'b0;
            ctrl_code_o        <= 16'h0000;
            ctrl_strobe_o      <= 1'b0;
            reinit_o           <= 1'b0;
            accept_bitstream_o <= 1'b0;
            flush_o            <= 1'b0;
            decode_run_o       <= 1'b0;
            audio_run_o        <= 1'b0;
            display_o          <= 2'h0;
            position_o         <= 64'h0;
            last_hires         <= 1'b0;
            hires_mode         <= 1'b0;
        end
        else
        begin
            cmd_ready_o        <= !(busy || is_play) || is_reinit;
            cmd_error_o        <= is_bad;
            cmd_state_o        <= next_state;
            group_o            <= cmd_valid_i ? grp : group_o;
            set_strobe_o       <= is_set;
            set_code_o         <= is_set ? cmd_i.code : set_code_o;
            transcode_check_o  <= is_set && cmd_i.code == `FC_VIDEO_STANDARD;
            ctrl_strobe_o      <= is_ctrl || (is_set && hi_prio);
            ctrl_code_o        <= (is_ctrl || is_set && hi_prio) ? cmd_i.code : ctrl_code_o;
            reinit_o           <= is_reinit;
            accept_bitstream_o <= next_state != macro_cmd_pkg::CS_IDLE
                               && next_state != macro_cmd_pkg::CS_PAUSE;
            flush_o            <= is_still || (is_ctrl && cmd_i.code == `FC_BUFFER_DISCARD);
            decode_run_o       <= next_state == macro_cmd_pkg::CS_STILL
                               || next_state == macro_cmd_pkg::CS_PLAYING
                               || next_state == macro_cmd_pkg::CS_FREEZE;
            audio_run_o        <= is_reinit ? 1'b0
                               : (still_act && multi && !still_fin)
                                  ? (audio_run_o || audio_unit_i)
                               : (next_state == macro_cmd_pkg::CS_FREEZE
                                  || next_state == macro_cmd_pkg::CS_PLAYING);
            display_o          <= next_display;
            if (is_play && pos_ok)
                position_o <= {cmd_i.start1, cmd_i.start2, cmd_i.stop1, cmd_i.stop2};
            if (pic_end)
                last_hires <= pic_hires_i;
            else if (is_play && !is_still)
                last_hires <= 1'b0;
            if (is_still || state == macro_cmd_pkg::CS_IDLE)
                hires_mode <= cfg_sync;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_set_keeps_state;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (is_set && !busy && state != macro_cmd_pkg::CS_PLAY_SETUP
         && state != macro_cmd_pkg::CS_STILL) |=> cmd_state_o == $past(state);
    endproperty
    a_set_keeps_state: assert property (p_set_keeps_state)
        else $error("Settings command changed state");

    property p_transcode_only_video;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        transcode_check_o |-> set_code_o == `FC_VIDEO_STANDARD && set_strobe_o;
    endproperty
    a_transcode_only_video: assert property (p_transcode_only_video)
        else $error("Transcode flag from wrong command");

    property p_play_setup;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (is_play && !is_reinit) |=> cmd_state_o == 3'h1 && accept_bitstream_o && !cmd_ready_o;
    endproperty
    a_play_setup: assert property (p_play_setup)
        else $error("Playback command did not enter setup");

    property p_ctrl_any_state;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && grp == macro_cmd_pkg::GRP_CONTROL) |=> ctrl_strobe_o;
    endproperty
    a_ctrl_any_state: assert property (p_ctrl_any_state)
        else $error("Control command refused");

    property p_reinit;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && cmd_i.code == `FC_REINIT) |=> reinit_o && cmd_state_o == 3'h0;
    endproperty
    a_reinit: assert property (p_reinit)
        else $error("Reinit did not reset state");

    property p_still_flush;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        is_still |=> flush_o ##1 (cmd_state_o == 3'h2 || reinit_o);
    endproperty
    a_still_flush: assert property (p_still_flush)
        else $error("Still did not flush and decode");

    property p_still_freeze;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (still_fin && !cmd_valid_i) |=> cmd_state_o == 3'h3 && audio_run_o;
    endproperty
    a_still_freeze: assert property (p_still_freeze)
        else $error("Still did not end frozen");

    property p_normal_frozen;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (still_act && !pic_hires_i && !pic_done_i && !cmd_valid_i
         && display_o == 2'h1) |=> display_o == 2'h1;
    endproperty
    a_normal_frozen: assert property (p_normal_frozen)
        else $error("Normal still display not frozen");

    property p_blank_after_normal;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (still_act && pic_hires_i && !last_hires && !pic_done_i && !cmd_valid_i)
            |=> display_o == 2'h2;
    endproperty
    a_blank_after_normal: assert property (p_blank_after_normal)
        else $error("No blank after normal resolution");

    c_still:    cover property (@(posedge ref_clk_i) is_still ##[1:20] still_fin);
    c_multi:    cover property (@(posedge ref_clk_i) still_act && multi && audio_unit_i);
    c_overwrite: cover property (@(posedge ref_clk_i) display_o == 2'h3);
    c_reinit:   cover property (@(posedge ref_clk_i) is_reinit);

endmodule : macro_cmd_dispatch

// ---- rtl/macro_cmd_pkg.sv ----
// Types shared by the macro command dispatcher
package macro_cmd_pkg;
    typedef enum logic [2:0] {
        CS_IDLE       = 3'h0,
        CS_PLAY_SETUP = 3'h1,
        CS_STILL      = 3'h2,
        CS_FREEZE     = 3'h3,
        CS_PAUSE      = 3'h4,
        CS_PLAYING    = 3'h5
    } cmd_state_type;

    typedef enum logic [1:0] {
        GRP_SET     = 2'h0,
        GRP_PLAY    = 2'h1,
        GRP_CONTROL = 2'h2,
        GRP_NONE    = 2'h3
    } group_type;

    typedef enum logic [1:0] {
        DISP_LIVE      = 2'h0,
        DISP_FROZEN    = 2'h1,
        DISP_BLANK     = 2'h2,
        DISP_OVERWRITE = 2'h3
    } disp_type;

    typedef struct packed {
        logic [15:0] code;
        logic [15:0] start1;
        logic [15:0] start2;
        logic [15:0] stop1;
        logic [15:0] stop2;
    } cmd_type;
endpackage : macro_cmd_pkg
